// File: verilog/mrx_pkg.sv
`default_nettype none
package mrx_pkg;

   // Default widths of the datapath
   localparam int DATA_W    = 8;
   localparam int DADDR_W   = 7;
   localparam int PC_W      = 11;
   localparam int DMEM_WORDS = 96;

   // Reset values of the programmer-visible state
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic              GIE_RESET = 1'b0;

   // Bit positions inside a byte
   localparam int MSB_POS  = 7;
   localparam int LSB_POS  = 0;
   localparam int HALF_POS = 4;

   // Program counter step for a sequential instruction
   localparam int PC_STEP = 1;

   // Operations this execution group understands
   typedef enum logic [4:0] {
      OP_IDLE           = 5'h00,
      OP_COPY_MEM_ACC   = 5'h01,
      OP_COPY_IMM_ACC   = 5'h02,
      OP_COPY_ACC_MEM   = 5'h03,
      OP_OR_MEM_ACC     = 5'h04,
      OP_OR_IMM_ACC     = 5'h05,
      OP_OR_TO_MEM      = 5'h06,
      OP_SUB_EXIT       = 5'h07,
      OP_EXIT_IMM       = 5'h08,
      OP_INT_EXIT       = 5'h09,
      OP_ROT_L          = 5'h0a,
      OP_ROT_L_ACC      = 5'h0b,
      OP_ROT_L_FLAG     = 5'h0c,
      OP_ROT_L_FLAG_ACC = 5'h0d,
      OP_ROT_R          = 5'h0e,
      OP_ROT_R_ACC      = 5'h0f,
      OP_ROT_R_FLAG     = 5'h10,
      OP_ROT_R_FLAG_ACC = 5'h11,
      OP_SUB_BORROW     = 5'h12,
      OP_SUB_BORROW_MEM = 5'h13,
      OP_DEC_SKIP       = 5'h14,
      OP_DEC_ACC_SKIP   = 5'h15
   } mrx_op_t;

   // One decoded instruction
   typedef struct packed {
      mrx_op_t              op;
      logic [DADDR_W-1:0]   addr;
      logic [DATA_W-1:0]    imm;
   } mrx_instr_t;

   // Arithmetic status flags
   typedef struct packed {
      logic signedRange;
      logic resultNull;
      logic halfCarry;
      logic carry;
   } mrx_flags_t;

   localparam mrx_flags_t FLAGS_RESET = 4'h0;

   // Execution states; Gray order along issue, exec, dummy
   typedef enum logic [1:0] {
      ST_ISSUE  = 2'b00,
      ST_EXEC   = 2'b01,
      ST_DUMMY1 = 2'b11,
      ST_DUMMY2 = 2'b10
   } mrx_state_t;

endpackage : mrx_pkg
`default_nettype wire

// File: verilog/mrx_data_ram.sv
`timescale 1ns/1ps
`default_nettype none
module mrx_data_ram #(
   parameter int WORDS  = mrx_pkg::DMEM_WORDS,
   parameter int ADDR_W = mrx_pkg::DADDR_W,
   parameter int DATA_W = mrx_pkg::DATA_W
) (
   input  wire logic              clk,    // System clock
   input  wire logic [ADDR_W-1:0] rdAddr, // Read address
   output logic      [DATA_W-1:0] rdData, // Registered read data
   input  wire logic              wrEn,   // Write strobe
   input  wire logic [ADDR_W-1:0] wrAddr, // Write address
   input  wire logic [DATA_W-1:0] wrData  // Write data
);

   logic [DATA_W-1:0] mem [WORDS];

   // Write port; out-of-range addresses are dropped
   always_ff @(posedge clk) begin
      if (wrEn && (int'(wrAddr) < WORDS)) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Registered read; out-of-range reads return zero
   always_ff @(posedge clk) begin
      if (int'(rdAddr) < WORDS) begin
         rdData <= mem[rdAddr];
      end else begin
         rdData <= '0;
      end
   end

endmodule : mrx_data_ram
`default_nettype wire

// File: verilog/mrx_exec_unit.sv
// How it works
// RULE1 - Memory copied into accumulator, flags untouched
// RULE2 - Immediate byte loaded into accumulator, no flags
// RULE3 - Accumulator written to memory, no flags
// RULE4 - Idle only advances program counter
// RULE5 - OR memory into accumulator, null flag
// RULE6 - OR immediate into accumulator, null flag
// RULE7 - OR result written to memory, null flag
// RULE8 - Subroutine exit pops stack, three cycles
// RULE9 - Exit with immediate loads accumulator too
// RULE10 - Interrupt exit pops and sets global enable
// RULE11 - Plain left rotate, to memory or accumulator
// RULE12 - Plain right rotate, to memory or accumulator
// RULE13 - Nine-bit left rotate through carry
// RULE14 - Nine-bit right rotate through carry
// RULE15 - Subtract with borrow into accumulator, four flags
// RULE16 - Subtract with borrow into memory, four flags
// RULE17 - Decrement memory, skip next when zero
// RULE18 - Decrement into accumulator, skip when zero
// RULE19 - Taken skip flushes prefetch, adds two dummy cycles
// RULE20 - Other instructions: one cycle, counter plus one
`timescale 1ns/1ps
`default_nettype none
module mrx_exec_unit #(
   parameter int PC_W   = mrx_pkg::PC_W,
   parameter int WORDS  = mrx_pkg::DMEM_WORDS
) (
   input  wire logic                          clk,             // System clock, 10 MHz
   input  wire logic                          srst,            // Synchronous reset, active high
   input  wire logic                          instrValid,      // Decoded instruction offered
   input  wire mrx_pkg::mrx_instr_t           instr,           // Decoded instruction
   output logic                               instrReady,      // Ready to take an instruction this clock
   output logic                               instrDone,       // Last clock of an instruction
   input  wire logic [PC_W-1:0]               stackTop,        // Return address on stack top
   output logic                               stackPop,        // Pop the return stack
   output logic                               flushPrefetch,   // Discard prefetched opcode
   output logic [PC_W-1:0]                    pc,              // Program counter
   output logic [mrx_pkg::DATA_W-1:0]         acc,             // Accumulator
   output mrx_pkg::mrx_flags_t                flags,           // Arithmetic status flags
   output logic                               globalIntEnable, // Global interrupt enable
   input  wire logic                          hostWrEn,        // Preload write strobe
   input  wire logic [mrx_pkg::DADDR_W-1:0]   hostAddr,        // Preload address
   input  wire logic [mrx_pkg::DATA_W-1:0]    hostData         // Preload data
);

   localparam int DW = mrx_pkg::DATA_W;

   // Adder used by subtract with borrow: a + b + cin, with flags; caller passes inverted b
   function automatic logic [DW+2:0] addFlags(input logic [DW-1:0] a,
                                              input logic [DW-1:0] b,
                                              input logic          cin);
      logic [DW:0]   full;
      logic [DW/2:0] low;
      logic [DW-1:0] lower7;
      logic          c7;
      full   = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, cin};
      low    = {1'b0, a[mrx_pkg::HALF_POS-1:0]} + {1'b0, b[mrx_pkg::HALF_POS-1:0]}
               + {{mrx_pkg::HALF_POS{1'b0}}, cin};
      lower7 = {1'b0, a[DW-2:0]} + {1'b0, b[DW-2:0]} + {{(DW-1){1'b0}}, cin};
      c7     = lower7[DW-1];
      // Result, signed range, half carry, carry
      addFlags = {full[DW-1:0], c7 ^ full[DW], low[mrx_pkg::HALF_POS], full[DW]};
   endfunction : addFlags

   // Left rotate, bit 7 into bit 0 or given fill
   function automatic logic [DW-1:0] rotLeft(input logic [DW-1:0] v, input logic fill);
      rotLeft = {v[DW-2:0], fill};
   endfunction : rotLeft

   // Right rotate, bit 0 into bit 7 or given fill
   function automatic logic [DW-1:0] rotRight(input logic [DW-1:0] v, input logic fill);
      rotRight = {fill, v[DW-1:1]};
   endfunction : rotRight

   // Registered state and its next values
   mrx_pkg::mrx_state_t  state;
   mrx_pkg::mrx_state_t  next_state;
   mrx_pkg::mrx_instr_t  cur;
   mrx_pkg::mrx_instr_t  next_cur;
   logic [PC_W-1:0]      next_pc;
   logic [DW-1:0]        next_acc;
   mrx_pkg::mrx_flags_t  next_flags;
   logic                 next_globalIntEnable;

   // Memory port and shared operand nets
   logic [DW-1:0]        memRd;
   logic                 memWrEn;
   logic [DW-1:0]        memWrData;
   logic                 execWr;
   logic [DW-1:0]        execWrData;
   logic [mrx_pkg::DADDR_W-1:0] memRdAddr;
   logic [mrx_pkg::DADDR_W-1:0] memWrAddr;
   logic [DW+2:0]        sbcOut;
   logic [DW-1:0]        decVal;

   // Data memory holding the operand bytes
   mrx_data_ram #(
      .WORDS  (WORDS),
      .ADDR_W (mrx_pkg::DADDR_W),
      .DATA_W (DW)
   ) u_ram (
      .clk    (clk),
      .rdAddr (memRdAddr),
      .rdData (memRd),
      .wrEn   (memWrEn),
      .wrAddr (memWrAddr),
      .wrData (memWrData)
   );

   // Handshakes and memory port steering
   assign instrReady = (state == mrx_pkg::ST_ISSUE);
   assign memRdAddr  = (state == mrx_pkg::ST_ISSUE) ? instr.addr : cur.addr;
   assign memWrEn    = execWr | hostWrEn;
   assign memWrAddr  = execWr ? cur.addr : hostAddr;   // Executing write beats preload
   assign memWrData  = execWr ? execWrData : hostData;

   // Operand arithmetic shared by several operations
   assign sbcOut     = addFlags(acc, ~memRd, flags.carry);
   assign decVal     = memRd - 8'h01;

   // Next-state and datapath computation
   always_comb begin
      next_state           = state;
      next_cur             = cur;
      next_pc              = pc;
      next_acc             = acc;
      next_flags           = flags;
      next_globalIntEnable = globalIntEnable;
      execWr               = 1'b0;
      execWrData           = acc;
      stackPop             = 1'b0;
      flushPrefetch        = 1'b0;
      instrDone            = 1'b0;
      case (state)
         mrx_pkg::ST_ISSUE: begin
            if (instrValid) begin
               next_cur   = instr;                  // Operand read starts now
               next_state = mrx_pkg::ST_EXEC;
            end
         end
         mrx_pkg::ST_EXEC: begin
            next_pc    = pc + PC_W'(mrx_pkg::PC_STEP); // RULE20
            next_state = mrx_pkg::ST_ISSUE;
            instrDone  = 1'b1;
            // Per-operation results on top of the one-cycle default
            case (cur.op)
               // Copies and idle touch no flags
               mrx_pkg::OP_IDLE: begin
                  next_pc = pc + PC_W'(mrx_pkg::PC_STEP); // RULE4
               end
               mrx_pkg::OP_COPY_MEM_ACC: begin
                  next_acc = memRd;                 // RULE1
               end
               mrx_pkg::OP_COPY_IMM_ACC: begin
                  next_acc = cur.imm;               // RULE2
               end
               mrx_pkg::OP_COPY_ACC_MEM: begin
                  execWr     = 1'b1;                // RULE3
                  execWrData = acc;
               end
               // OR operations update only the null flag
               mrx_pkg::OP_OR_MEM_ACC: begin
                  next_acc              = acc | memRd;             // RULE5
                  next_flags.resultNull = ((acc | memRd) == '0);   // RULE5
               end
               mrx_pkg::OP_OR_IMM_ACC: begin
                  next_acc              = acc | cur.imm;           // RULE6
                  next_flags.resultNull = ((acc | cur.imm) == '0); // RULE6
               end
               mrx_pkg::OP_OR_TO_MEM: begin
                  execWr                = 1'b1;                    // RULE7
                  execWrData            = acc | memRd;
                  next_flags.resultNull = ((acc | memRd) == '0);   // RULE7
               end
               // Returns pop the stack and add two dummy clocks
               mrx_pkg::OP_SUB_EXIT: begin
                  stackPop   = 1'b1;                // RULE8
                  next_pc    = stackTop;
                  instrDone  = 1'b0;
                  next_state = mrx_pkg::ST_DUMMY1;
               end
               mrx_pkg::OP_EXIT_IMM: begin
                  stackPop   = 1'b1;                // RULE9
                  next_pc    = stackTop;
                  next_acc   = cur.imm;             // RULE9
                  instrDone  = 1'b0;
                  next_state = mrx_pkg::ST_DUMMY1;
               end
               mrx_pkg::OP_INT_EXIT: begin
                  stackPop             = 1'b1;      // RULE10
                  next_pc              = stackTop;
                  next_globalIntEnable = 1'b1;      // RULE10
                  instrDone            = 1'b0;
                  next_state           = mrx_pkg::ST_DUMMY1;
               end
               // Rotates; only the carry variants touch a flag
               mrx_pkg::OP_ROT_L: begin
                  execWr     = 1'b1;                // RULE11
                  execWrData = rotLeft(memRd, memRd[mrx_pkg::MSB_POS]);
               end
               mrx_pkg::OP_ROT_L_ACC: begin
                  next_acc = rotLeft(memRd, memRd[mrx_pkg::MSB_POS]); // RULE11
               end
               mrx_pkg::OP_ROT_R: begin
                  execWr     = 1'b1;                // RULE12
                  execWrData = rotRight(memRd, memRd[mrx_pkg::LSB_POS]);
               end
               mrx_pkg::OP_ROT_R_ACC: begin
                  next_acc = rotRight(memRd, memRd[mrx_pkg::LSB_POS]); // RULE12
               end
               mrx_pkg::OP_ROT_L_FLAG: begin
                  execWr           = 1'b1;          // RULE13
                  execWrData       = rotLeft(memRd, flags.carry);
                  next_flags.carry = memRd[mrx_pkg::MSB_POS];
               end
               mrx_pkg::OP_ROT_L_FLAG_ACC: begin
                  next_acc         = rotLeft(memRd, flags.carry); // RULE13
                  next_flags.carry = memRd[mrx_pkg::MSB_POS];
               end
               mrx_pkg::OP_ROT_R_FLAG: begin
                  execWr           = 1'b1;          // RULE14
                  execWrData       = rotRight(memRd, flags.carry);
                  next_flags.carry = memRd[mrx_pkg::LSB_POS];
               end
               mrx_pkg::OP_ROT_R_FLAG_ACC: begin
                  next_acc         = rotRight(memRd, flags.carry); // RULE14
                  next_flags.carry = memRd[mrx_pkg::LSB_POS];
               end
               // Subtract with borrow updates four flags
               mrx_pkg::OP_SUB_BORROW: begin
                  next_acc               = sbcOut[DW+2:3];          // RULE15
                  next_flags.signedRange = sbcOut[2];
                  next_flags.halfCarry   = sbcOut[1];
                  next_flags.carry       = sbcOut[0];
                  next_flags.resultNull  = (sbcOut[DW+2:3] == '0);
               end
               mrx_pkg::OP_SUB_BORROW_MEM: begin
                  execWr                 = 1'b1;                    // RULE16
                  execWrData             = sbcOut[DW+2:3];
                  next_flags.signedRange = sbcOut[2];
                  next_flags.halfCarry   = sbcOut[1];
                  next_flags.carry       = sbcOut[0];
                  next_flags.resultNull  = (sbcOut[DW+2:3] == '0);
               end
               // Decrements never touch flags; zero result skips
               mrx_pkg::OP_DEC_SKIP: begin
                  execWr     = 1'b1;                // RULE17
                  execWrData = decVal;
                  if (decVal == '0) begin
                     flushPrefetch = 1'b1;          // RULE19
                     instrDone     = 1'b0;
                     next_state    = mrx_pkg::ST_DUMMY1;
                  end
               end
               mrx_pkg::OP_DEC_ACC_SKIP: begin
                  next_acc = decVal;                // RULE18
                  if (decVal == '0) begin
                     flushPrefetch = 1'b1;          // RULE19
                     instrDone     = 1'b0;
                     next_state    = mrx_pkg::ST_DUMMY1;
                  end
               end
               default: begin
                  next_pc = pc + PC_W'(mrx_pkg::PC_STEP);
               end
            endcase
            // Skip steps over the discarded word
            if (flushPrefetch) begin
               next_pc = pc + PC_W'(2 * mrx_pkg::PC_STEP); // RULE19
            end
         end
         // Dummy clocks stand in for the discarded fetch
         mrx_pkg::ST_DUMMY1: begin
            next_state = mrx_pkg::ST_DUMMY2;        // RULE19
         end
         mrx_pkg::ST_DUMMY2: begin
            instrDone  = 1'b1;                      // RULE8
            next_state = mrx_pkg::ST_ISSUE;
         end
         default: begin
            next_state = mrx_pkg::ST_ISSUE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge clk) begin
      if (srst) begin
         state           <= mrx_pkg::ST_ISSUE;
         cur             <= '0;
         pc              <= '0;
         acc             <= mrx_pkg::ACC_RESET;
         flags           <= mrx_pkg::FLAGS_RESET;
         globalIntEnable <= mrx_pkg::GIE_RESET;
      end else begin
         state           <= next_state;
         cur             <= next_cur;
         pc              <= next_pc;
         acc             <= next_acc;
         flags           <= next_flags;
         globalIntEnable <= next_globalIntEnable;
      end
   end

endmodule : mrx_exec_unit
`default_nettype wire

// File: verification/mrx_exec_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mrx_exec_checker #(
   parameter int PC_W = 11
) (
   input wire logic                clk,            // Clock
   input wire logic                srst,           // Reset
   input wire logic                instrValid,     // Offered
   input wire mrx_pkg::mrx_instr_t instr,          // Instruction
   input wire logic                instrReady,     // Ready
   input wire logic                instrDone,      // Done
   input wire logic [PC_W-1:0]     stackTop,       // Return address
   input wire logic                stackPop,       // Pop
   input wire logic                flushPrefetch,  // Flush
   input wire logic [PC_W-1:0]     pc,             // Counter
   input wire logic [7:0]          acc,            // Accumulator
   input wire mrx_pkg::mrx_flags_t flags,          // Flags
   input wire logic                globalIntEnable // Global enable
);
   // One clock domain
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Acceptance and opcode classes
   wire take  = instrValid && instrReady;
   wire isRet = instr.op inside {[5'h07:5'h09]};
   wire isDec = instr.op inside {[5'h14:5'h15]};
   // Two dummy clocks, then ready
   sequence s_dummy;
      !instrReady && !instrDone ##1 instrDone && !instrReady ##1 instrReady;
   endsequence
   // Timing, counter and result relations
   property p_ret_pop;
      take && isRet |=> stackPop && !instrDone ##1 s_dummy;
   endproperty
   a_ret_pop: assert property (p_ret_pop) else $error("return timing wrong");
   property p_ret_pc;
      stackPop |=> pc == $past(stackTop);
   endproperty
   a_ret_pc: assert property (p_ret_pc) else $error("return target wrong");
   property p_int_en;
      take && instr.op == mrx_pkg::OP_INT_EXIT |=> ##1 globalIntEnable;
   endproperty
   a_int_en: assert property (p_int_en) else $error("global enable not set");
   property p_imm;
      take && instr.op inside {5'h02, 5'h08} |=> ##1 acc == $past(instr.imm, 2);
   endproperty
   a_imm: assert property (p_imm) else $error("immediate load wrong");
   property p_skip;
      flushPrefetch |=> pc == $past(pc) + PC_W'(2) ##0 s_dummy;
   endproperty
   a_skip: assert property (p_skip) else $error("skip timing wrong");
   property p_single;
      take && !isRet && !isDec |=> instrDone && !stackPop && !flushPrefetch
         ##1 instrReady && pc == $past(pc, 2) + PC_W'(1);
   endproperty
   a_single: assert property (p_single) else $error("single cycle wrong");
   property p_flags;
      take && (isDec || instr.op inside {[5'h00:5'h03], [5'h07:5'h0b], 5'h0e, 5'h0f})
         |=> ##1 flags == $past(flags, 2);
   endproperty
   a_flags: assert property (p_flags) else $error("flags changed");
   property p_or_imm;
      take && instr.op == 5'h05 |=> ##1 acc == ($past(acc, 2) | $past(instr.imm, 2))
         && flags.resultNull == (acc == 8'h00) && flags.carry == $past(flags.carry, 2);
   endproperty
   a_or_imm: assert property (p_or_imm) else $error("or immediate wrong");
endmodule : mrx_exec_checker
bind mrx_exec_unit mrx_exec_checker #(.PC_W(PC_W)) mrx_exec_checker_inst (
   .clk(clk), .srst(srst), .instrValid(instrValid), .instr(instr), .instrReady(instrReady),
   .instrDone(instrDone), .stackTop(stackTop), .stackPop(stackPop), .pc(pc), .acc(acc),
   .flushPrefetch(flushPrefetch), .flags(flags), .globalIntEnable(globalIntEnable));
`default_nettype wire

// File: verification/test_mrx_exec_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_mrx_exec_unit;
   logic                clk;
   logic                srst       = 1'b1;
   logic                instrValid = 1'b0;
   mrx_pkg::mrx_instr_t instr      = '0;
   logic                instrReady;
   logic                instrDone;
   logic [10:0]         stackTop   = 11'h000;
   logic                stackPop;
   logic                flushPrefetch;
   logic [10:0]         pc;
   logic [7:0]          acc;
   mrx_pkg::mrx_flags_t flags;
   logic                globalIntEnable;
   logic                hostWrEn   = 1'b0;
   logic [6:0]          hostAddr   = 7'h00;
   logic [7:0]          hostData   = 8'h00;
   logic [10:0]         expPc      = 11'h000;
   logic                expGie     = 1'b0;
   int                  nMismatch  = 0;
   int                  compares   = 0;
   mrx_exec_unit mrx_exec_unit_inst (
      .clk(clk), .srst(srst), .instrValid(instrValid), .instr(instr), .instrReady(instrReady),
      .instrDone(instrDone), .stackTop(stackTop), .stackPop(stackPop), .pc(pc), .acc(acc),
      .flushPrefetch(flushPrefetch), .flags(flags), .globalIntEnable(globalIntEnable),
      .hostWrEn(hostWrEn), .hostAddr(hostAddr), .hostData(hostData));
   // Free-running 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         nMismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Counts and verdict
   task automatic printVerdict();
      $display("compares %0d mismatches %0d", compares, nMismatch);
      if (nMismatch == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : printVerdict
   // One preload write into data memory
   task automatic memWr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      hostWrEn <= 1'b1;
      hostAddr <= a;
      hostData <= d;
      @(posedge clk);
      hostWrEn <= 1'b0;
   endtask : memWr
   // Issue one instruction, wait for completion, check results
   task automatic step(input logic [4:0] op, input logic [6:0] a, input logic [7:0] im,
                       input logic [7:0] eAcc, input logic [3:0] eFl, input logic tk);
      int   n    = 0;
      logic pops = 1'b0;
      logic fl   = 1'b0;
      logic ret  = op inside {[5'h07:5'h09]};
      @(posedge clk);
      stackTop   <= expPc + 11'h123;
      instrValid <= 1'b1;
      instr      <= '{op: mrx_pkg::mrx_op_t'(op), addr: a, imm: im};
      @(posedge clk);
      instrValid <= 1'b0;
      expPc  = ret ? expPc + 11'h123 : expPc + (tk ? 11'h002 : 11'h001);
      expGie = expGie | (op == 5'h09);
      do begin
         @(negedge clk);
         n++;
         pops |= stackPop;
         fl   |= flushPrefetch;
      end while (instrDone !== 1'b1 && n < 6);
      chk("cycles", 16'(n), (ret || tk) ? 16'h0003 : 16'h0001);
      if (instrDone !== 1'b1) printVerdict();
      @(negedge clk);
      chk("pop", 16'(pops), 16'(ret));
      chk("flush", 16'(fl), 16'(tk));
      chk("pc", 16'(pc), 16'(expPc));
      chk("acc", 16'(acc), 16'(eAcc));
      chk("flags", 16'(flags), 16'(eFl));
      chk("gie", 16'(globalIntEnable), 16'(expGie));
   endtask : step
   // Reset, preload, then the instruction sequence
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk("rstState", {1'b0, pc, flags}, 16'h0000);
      chk("rstAcc", {7'h00, acc, globalIntEnable}, 16'h0000);
      memWr(7'h05, 8'h81);
      memWr(7'h14, 8'h80);
      memWr(7'h1e, 8'h40);
      step(5'h01, 7'h05, 8'h00, 8'h81, 4'h0, 1'b0);
      step(5'h02, 7'h00, 8'ha5, 8'ha5, 4'h0, 1'b0);
      step(5'h03, 7'h0a, 8'h00, 8'ha5, 4'h0, 1'b0);
      step(5'h00, 7'h00, 8'h00, 8'ha5, 4'h0, 1'b0);
      step(5'h02, 7'h00, 8'h00, 8'h00, 4'h0, 1'b0);
      step(5'h05, 7'h00, 8'h00, 8'h00, 4'h4, 1'b0);
      step(5'h05, 7'h00, 8'h12, 8'h12, 4'h0, 1'b0);
      step(5'h04, 7'h05, 8'h00, 8'h93, 4'h0, 1'b0);
      step(5'h06, 7'h0a, 8'h00, 8'h93, 4'h0, 1'b0);
      step(5'h01, 7'h0a, 8'h00, 8'hb7, 4'h0, 1'b0);
      step(5'h0b, 7'h05, 8'h00, 8'h03, 4'h0, 1'b0);
      step(5'h0f, 7'h05, 8'h00, 8'hc0, 4'h0, 1'b0);
      step(5'h0a, 7'h05, 8'h00, 8'hc0, 4'h0, 1'b0);
      step(5'h0e, 7'h05, 8'h00, 8'hc0, 4'h0, 1'b0);
      step(5'h0d, 7'h14, 8'h00, 8'h00, 4'h1, 1'b0);
      step(5'h0d, 7'h05, 8'h00, 8'h03, 4'h1, 1'b0);
      step(5'h11, 7'h14, 8'h00, 8'hc0, 4'h0, 1'b0);
      step(5'h10, 7'h05, 8'h00, 8'hc0, 4'h1, 1'b0);
      step(5'h01, 7'h05, 8'h00, 8'h40, 4'h1, 1'b0);
      step(5'h0c, 7'h14, 8'h00, 8'h40, 4'h1, 1'b0);
      step(5'h12, 7'h1e, 8'h00, 8'h00, 4'h7, 1'b0);
      step(5'h02, 7'h00, 8'h81, 8'h81, 4'h7, 1'b0);
      step(5'h13, 7'h1e, 8'h00, 8'h81, 4'hb, 1'b0);
      step(5'h01, 7'h1e, 8'h00, 8'h41, 4'hb, 1'b0);
      step(5'h15, 7'h1e, 8'h00, 8'h40, 4'hb, 1'b0);
      step(5'h15, 7'h14, 8'h00, 8'h00, 4'hb, 1'b1);
      step(5'h01, 7'h14, 8'h00, 8'h01, 4'hb, 1'b0);
      step(5'h14, 7'h14, 8'h00, 8'h01, 4'hb, 1'b1);
      step(5'h14, 7'h14, 8'h00, 8'h01, 4'hb, 1'b0);
      step(5'h07, 7'h00, 8'h00, 8'h01, 4'hb, 1'b0);
      step(5'h08, 7'h00, 8'h5a, 8'h5a, 4'hb, 1'b0);
      step(5'h09, 7'h00, 8'h00, 8'h5a, 4'hb, 1'b0);
      printVerdict();
   end
endmodule : test_mrx_exec_unit
`default_nettype wire
